// ===== rtl/cpst_params.svh
// constants of the cell protection status and trim block
`ifndef CPST_PARAMS_SVH
`define CPST_PARAMS_SVH

`define CPST_IDX_SSC 16'h0000
`define CPST_IDX_IRQ_STAT 16'h0001
`define CPST_IDX_IRQ_EN 16'h0002
`define CPST_IDX_IRQ_CLR 16'h0003
`define CPST_IDX_TRIM_KEY 16'h001d
`define CPST_IDX_TRIM_GAIN 16'h001e
`define CPST_IDX_TRIM_VT 16'h001f
`define CPST_IDX_ADC_CFG 16'h600a

`define CPST_FLAG_LSB 11
`define CPST_FLAG_MSB 15
`define CPST_CHG_MIRROR_BIT 9
`define CPST_DIS_MIRROR_BIT 8
`define CPST_CE_BIT 3
`define CPST_DISEN_BIT 2
`define CPST_MODE_MSB 1
`define CPST_MODE_LSB 0

`define CPST_F_LOWV 0
`define CPST_F_HIGHV 1
`define CPST_F_SHORT 2
`define CPST_F_DISOC 3
`define CPST_F_CHGOC 4
`define CPST_F_TCHG 5
`define CPST_F_TDIS 6
`define CPST_F_SLEEP 7
`define CPST_NFLAG 5

`define CPST_TRIM_KEY_VALID 8'h76
`define CPST_DEF_SLAVE_ADDR 7'h0b
`define CPST_DEF_TEMPCO 8'h00
`define CPST_DEF_VT_WORD 16'h170a
`define CPST_TLIME_BIT 7
`define CPST_MODE_RESET 2'h0
`define CPST_MODE_GATES 2'h3
`define CPST_MODE_ADC_OFF 2'h0

`endif

// ===== rtl/cpst_pkg.sv
// types of the cell protection status and trim block
package cpst_pkg;
	typedef enum logic [1:0] {CPST_IDLE, CPST_WR, CPST_RD} cpst_phase_t;
	typedef logic [15:0] cpst_word_t;
endpackage

// ===== rtl/cpst_sync.sv
// two flip-flop synchroniser for the fault and sleep levels
`timescale 1ns/10ps
module cpst_sync #(
	parameter int W = 8
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= meta_next;
			q <= q_next;
		end
	end
endmodule // cpst_sync

// ===== rtl/cpst_top.sv
// cell protection status, gate control and user trim with ahb-lite registers
`timescale 1ns/10ps
`include "cpst_params.svh"
module cpst_top #(
	parameter logic [7:0] FACTORY_GAIN_TRIM = 8'h00
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic CHARGE_OVERCURRENT_FAULT,
	input wire logic DISCHARGE_OVERCURRENT_FAULT,
	input wire logic SHORT_CIRCUIT_FAULT,
	input wire logic HIGH_CELL_VOLTAGE_FAULT,
	input wire logic LOW_CELL_VOLTAGE_FAULT,
	input wire logic CHARGE_TEMP_FAULT,
	input wire logic DISCHARGE_TEMP_FAULT,
	input wire logic SLEEP_ACTIVE,
	output logic CHARGE_GATE_OUT,
	output logic DISCHARGE_GATE_OUT,
	output logic ADC_ENABLE,
	output cpst_pkg::cpst_word_t ADC_CONFIG,
	output cpst_pkg::cpst_word_t VOLT_TEMP_TRIM,
	output logic [6:0] SLAVE_ADDRESS,
	output logic [7:0] CURRENT_GAIN_TRIM,
	output logic [7:0] SENSE_RESISTOR_TEMPCO,
	output logic IRQ
);
	import cpst_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation

	logic [7:0] fault_s;
	cpst_sync #(.W(8)) u_sync (
		.CLK(CLK),
		.RST(RST),
		.d({SLEEP_ACTIVE, DISCHARGE_TEMP_FAULT, CHARGE_TEMP_FAULT, CHARGE_OVERCURRENT_FAULT,
			DISCHARGE_OVERCURRENT_FAULT, SHORT_CIRCUIT_FAULT, HIGH_CELL_VOLTAGE_FAULT,
			LOW_CELL_VOLTAGE_FAULT}),
		.q(fault_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// bus phase tracking

	cpst_phase_t phase_reg, phase_next;
	logic [15:0] idx_reg, idx_next;
	logic hit_reg, hit_next;
	logic addr_take;

	assign addr_take = HSEL && HREADY && HTRANS[1];

	always_comb begin
		phase_next = CPST_IDLE;
		idx_next = idx_reg;
		hit_next = hit_reg;
		if (phase_reg == CPST_RD) begin
			// one wait state while the registered read data is loaded into HRDATA
			phase_next = CPST_IDLE;
		end else if (addr_take) begin
			phase_next = HWRITE ? CPST_WR : CPST_RD;
			idx_next = HADDR[17:2];
			hit_next = (HADDR[31:18] == 14'h0000);
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			phase_reg <= CPST_IDLE;
			idx_reg <= 16'h0000;
			hit_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			idx_reg <= idx_next;
			hit_reg <= hit_next;
		end
	end

	function automatic logic is_wr(input cpst_phase_t ph, input logic hit, input logic [15:0] idx,
			input logic [15:0] target);
		is_wr = (ph == CPST_WR) && hit && (idx == target);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// control, flag, trim and interrupt registers

	logic [`CPST_NFLAG-1:0] flag_reg, flag_next;
	logic ce_reg, ce_next;
	logic disen_reg, disen_next;
	logic [1:0] mode_reg, mode_next;
	cpst_word_t key_reg, key_next;
	cpst_word_t gain_reg, gain_next;
	cpst_word_t vt_reg, vt_next;
	cpst_word_t adc_reg, adc_next;
	logic [`CPST_NFLAG-1:0] ist_reg, ist_next;
	logic [`CPST_NFLAG-1:0] ien_reg, ien_next;
	logic [`CPST_NFLAG-1:0] fault_d_reg;
	logic [`CPST_NFLAG-1:0] clr_mask;
	logic wr_ssc;

	always_comb begin
		wr_ssc = is_wr(phase_reg, hit_reg, idx_reg, `CPST_IDX_SSC);
		ce_next = ce_reg;
		disen_next = disen_reg;
		mode_next = mode_reg;
		key_next = key_reg;
		gain_next = gain_reg;
		vt_next = vt_reg;
		adc_next = adc_reg;
		ien_next = ien_reg;
		clr_mask = '0;
		if (wr_ssc) begin
			ce_next = HWDATA[`CPST_CE_BIT];
			disen_next = HWDATA[`CPST_DISEN_BIT];
			mode_next = HWDATA[`CPST_MODE_MSB:`CPST_MODE_LSB];
			clr_mask = ~HWDATA[`CPST_FLAG_MSB:`CPST_FLAG_LSB];
		end
		if (is_wr(phase_reg, hit_reg, idx_reg, `CPST_IDX_TRIM_KEY))
			key_next = HWDATA[15:0];
		if (is_wr(phase_reg, hit_reg, idx_reg, `CPST_IDX_TRIM_GAIN))
			gain_next = HWDATA[15:0];
		if (is_wr(phase_reg, hit_reg, idx_reg, `CPST_IDX_TRIM_VT))
			vt_next = HWDATA[15:0];
		if (is_wr(phase_reg, hit_reg, idx_reg, `CPST_IDX_ADC_CFG))
			adc_next = HWDATA[15:0];
		if (is_wr(phase_reg, hit_reg, idx_reg, `CPST_IDX_IRQ_EN))
			ien_next = HWDATA[`CPST_NFLAG-1:0];
		// a live fault keeps its flag; set wins over the clear
		flag_next = fault_s[`CPST_NFLAG-1:0] | (flag_reg & ~clr_mask);
		ist_next = ist_reg;
		if (is_wr(phase_reg, hit_reg, idx_reg, `CPST_IDX_IRQ_CLR))
			ist_next = ist_reg & ~HWDATA[`CPST_NFLAG-1:0];
		ist_next = ist_next | (fault_s[`CPST_NFLAG-1:0] & ~fault_d_reg);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			flag_reg <= '0;
			ce_reg <= 1'b0;
			disen_reg <= 1'b0;
			mode_reg <= `CPST_MODE_RESET;
			key_reg <= 16'h0000;
			gain_reg <= 16'h0000;
			vt_reg <= 16'h0000;
			adc_reg <= 16'h0000;
			ist_reg <= '0;
			ien_reg <= '0;
			fault_d_reg <= '0;
		end else begin
			flag_reg <= flag_next;
			ce_reg <= ce_next;
			disen_reg <= disen_next;
			mode_reg <= mode_next;
			key_reg <= key_next;
			gain_reg <= gain_next;
			vt_reg <= vt_next;
			adc_reg <= adc_next;
			ist_reg <= ist_next;
			ien_reg <= ien_next;
			fault_d_reg <= fault_s[`CPST_NFLAG-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// trim selection and gate control

	logic key_ok;
	logic tlime;
	logic chg_next, dis_next;
	logic [6:0] sa_next;
	logic [7:0] gtrim_next, tc_next;
	cpst_word_t vtt_next;

	always_comb begin
		// one key gates every field at once
		key_ok = (key_reg[7:0] == `CPST_TRIM_KEY_VALID);
		sa_next = key_ok ? key_reg[14:8] : `CPST_DEF_SLAVE_ADDR;
		gtrim_next = key_ok ? gain_reg[15:8] : FACTORY_GAIN_TRIM;
		tc_next = key_ok ? gain_reg[7:0] : `CPST_DEF_TEMPCO;
		vtt_next = key_ok ? vt_reg : `CPST_DEF_VT_WORD;
		tlime = vtt_next[`CPST_TLIME_BIT];
		// gates use live faults so a write can never beat them
		chg_next = ce_reg && (mode_reg == `CPST_MODE_GATES) && !fault_s[`CPST_F_SLEEP]
			&& !fault_s[`CPST_F_HIGHV] && !fault_s[`CPST_F_LOWV] && !fault_s[`CPST_F_CHGOC]
			&& !(tlime && fault_s[`CPST_F_TCHG]);
		dis_next = disen_reg && (mode_reg == `CPST_MODE_GATES) && !fault_s[`CPST_F_SLEEP]
			&& !fault_s[`CPST_F_LOWV] && !fault_s[`CPST_F_CHGOC] && !fault_s[`CPST_F_DISOC]
			&& !fault_s[`CPST_F_SHORT] && !(tlime && fault_s[`CPST_F_TDIS]);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			CHARGE_GATE_OUT <= 1'b0;
			DISCHARGE_GATE_OUT <= 1'b0;
			ADC_ENABLE <= 1'b0;
			ADC_CONFIG <= 16'h0000;
			VOLT_TEMP_TRIM <= `CPST_DEF_VT_WORD;
			SLAVE_ADDRESS <= `CPST_DEF_SLAVE_ADDR;
			CURRENT_GAIN_TRIM <= FACTORY_GAIN_TRIM;
			SENSE_RESISTOR_TEMPCO <= `CPST_DEF_TEMPCO;
			IRQ <= 1'b0;
		end else begin
			// high pulls the gate to the pump, low clamps it to its off rail
			CHARGE_GATE_OUT <= chg_next;
			DISCHARGE_GATE_OUT <= dis_next;
			ADC_ENABLE <= (mode_reg != `CPST_MODE_ADC_OFF);
			ADC_CONFIG <= adc_reg;
			VOLT_TEMP_TRIM <= vtt_next;
			SLAVE_ADDRESS <= sa_next;
			CURRENT_GAIN_TRIM <= gtrim_next;
			SENSE_RESISTOR_TEMPCO <= tc_next;
			IRQ <= |(ist_reg & ien_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data and bus answer

	logic [31:0] rdata_next;
	logic ready_next;
	cpst_word_t ssc_word;

	always_comb begin
		ssc_word = 16'h0000;
		ssc_word[`CPST_FLAG_MSB:`CPST_FLAG_LSB] = flag_reg;
		ssc_word[`CPST_CHG_MIRROR_BIT] = CHARGE_GATE_OUT;
		ssc_word[`CPST_DIS_MIRROR_BIT] = DISCHARGE_GATE_OUT;
		ssc_word[`CPST_CE_BIT] = ce_reg;
		ssc_word[`CPST_DISEN_BIT] = disen_reg;
		ssc_word[`CPST_MODE_MSB:`CPST_MODE_LSB] = mode_reg;
		rdata_next = HRDATA;
		ready_next = 1'b1;
		if (phase_next == CPST_RD)
			ready_next = 1'b0;
		if (phase_reg == CPST_RD) begin
			rdata_next = 32'h00000000;
			if (hit_reg) begin
				unique case (idx_reg)
					`CPST_IDX_SSC: rdata_next = {16'h0000, ssc_word};
					`CPST_IDX_IRQ_STAT: rdata_next = {27'h0000000, ist_reg};
					`CPST_IDX_IRQ_EN: rdata_next = {27'h0000000, ien_reg};
					`CPST_IDX_TRIM_KEY: rdata_next = {16'h0000, key_reg};
					`CPST_IDX_TRIM_GAIN: rdata_next = {16'h0000, gain_reg};
					`CPST_IDX_TRIM_VT: rdata_next = {16'h0000, vt_reg};
					`CPST_IDX_ADC_CFG: rdata_next = {16'h0000, adc_reg};
					default: rdata_next = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HRDATA <= rdata_next;
			HREADYOUT <= ready_next;
			HRESP <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	flag_set_a: assert property (fault_s[`CPST_F_CHGOC] |=> flag_reg[`CPST_F_CHGOC])
		else $error("fault did not set its flag");
	flag_keep_a: assert property (flag_reg[`CPST_F_LOWV] && fault_s[`CPST_F_LOWV] |=> flag_reg[`CPST_F_LOWV])
		else $error("flag cleared while fault active");
	flag_clear_a: assert property (wr_ssc && !HWDATA[`CPST_FLAG_LSB] && !fault_s[`CPST_F_LOWV]
		|=> !flag_reg[`CPST_F_LOWV])
		else $error("flag not cleared by write of zero");
	flag_hold_a: assert property (flag_reg[`CPST_F_SHORT] && !wr_ssc |=> flag_reg[`CPST_F_SHORT])
		else $error("flag dropped without a software clear");
	chg_off_a: assert property (!ce_reg |=> !CHARGE_GATE_OUT)
		else $error("charge gate on with enable low");
	dis_off_a: assert property (!disen_reg |=> !DISCHARGE_GATE_OUT)
		else $error("discharge gate on with enable low");
	chg_block_a: assert property (fault_s[`CPST_F_HIGHV] |=> !CHARGE_GATE_OUT)
		else $error("charge gate on during high voltage");
	chg_fault_a: assert property (fault_s[`CPST_F_LOWV] || fault_s[`CPST_F_CHGOC] |=> !CHARGE_GATE_OUT)
		else $error("charge gate on during fault");
	chg_temp_a: assert property (tlime && fault_s[`CPST_F_TCHG] |=> !CHARGE_GATE_OUT)
		else $error("charge gate on during enabled temperature fault");
	dis_block_a: assert property (fault_s[`CPST_F_SHORT] || fault_s[`CPST_F_LOWV] |=> !DISCHARGE_GATE_OUT)
		else $error("discharge gate on during fault");
	dis_ocur_a: assert property (fault_s[`CPST_F_DISOC] || fault_s[`CPST_F_CHGOC] |=> !DISCHARGE_GATE_OUT)
		else $error("discharge gate on during overcurrent");
	dis_temp_a: assert property (tlime && fault_s[`CPST_F_TDIS] |=> !DISCHARGE_GATE_OUT)
		else $error("discharge gate on during enabled temperature fault");
	sleep_off_a: assert property (fault_s[`CPST_F_SLEEP] |=> !CHARGE_GATE_OUT && !DISCHARGE_GATE_OUT)
		else $error("gate on while asleep");
	chg_on_a: assert property (ce_reg && mode_reg == `CPST_MODE_GATES && !fault_s[`CPST_F_SLEEP]
		&& !fault_s[`CPST_F_HIGHV] && !fault_s[`CPST_F_LOWV] && !fault_s[`CPST_F_CHGOC]
		&& !(tlime && fault_s[`CPST_F_TCHG]) |=> CHARGE_GATE_OUT)
		else $error("charge gate off although allowed");
	dis_on_a: assert property (disen_reg && mode_reg == `CPST_MODE_GATES && !fault_s[`CPST_F_SLEEP]
		&& !fault_s[`CPST_F_LOWV] && !fault_s[`CPST_F_CHGOC] && !fault_s[`CPST_F_DISOC]
		&& !fault_s[`CPST_F_SHORT] && !(tlime && fault_s[`CPST_F_TDIS]) |=> DISCHARGE_GATE_OUT)
		else $error("discharge gate off although allowed");
	mode_low_a: assert property (mode_reg != `CPST_MODE_GATES |=> !CHARGE_GATE_OUT && !DISCHARGE_GATE_OUT)
		else $error("gates on outside gate mode");
	adc_off_a: assert property (mode_reg == `CPST_MODE_ADC_OFF |=> !ADC_ENABLE)
		else $error("adc enabled in off mode");
	adc_on_a: assert property (mode_reg != `CPST_MODE_ADC_OFF |=> ADC_ENABLE)
		else $error("adc disabled in measuring mode");
	irq_on_a: assert property (|(ist_reg & ien_reg) |=> IRQ)
		else $error("interrupt missing for enabled status");
	irq_off_a: assert property (!(|(ist_reg & ien_reg)) |=> !IRQ)
		else $error("interrupt without enabled status");
	key_default_a: assert property (!key_ok |=> SLAVE_ADDRESS == `CPST_DEF_SLAVE_ADDR
		&& CURRENT_GAIN_TRIM == FACTORY_GAIN_TRIM && SENSE_RESISTOR_TEMPCO == `CPST_DEF_TEMPCO)
		else $error("user trim used without key");
	mirror_rd_a: assert property (phase_reg == CPST_RD && hit_reg && idx_reg == `CPST_IDX_SSC
		|=> HREADYOUT && HRDATA[`CPST_CHG_MIRROR_BIT] == $past(CHARGE_GATE_OUT))
		else $error("charge gate mirror wrong");
	trim_user_a: assert property (key_ok |=> SLAVE_ADDRESS == $past(key_reg[14:8])
		&& CURRENT_GAIN_TRIM == $past(gain_reg[15:8]) && SENSE_RESISTOR_TEMPCO == $past(gain_reg[7:0]))
		else $error("user trim not applied with valid key");

	for (genvar gi = 0; gi < `CPST_NFLAG; gi++) begin : g_flag_chk
		flag_each_a: assert property (fault_s[gi] |=> flag_reg[gi])
			else $error("fault did not latch its flag");
		irq_set_a: assert property (fault_s[gi] && !fault_d_reg[gi] |=> ist_reg[gi])
			else $error("interrupt status missed a fault edge");
	end

	gates_on_c: cover property (CHARGE_GATE_OUT && DISCHARGE_GATE_OUT);
	fault_trip_c: cover property (DISCHARGE_GATE_OUT ##1 fault_s[`CPST_F_SHORT] ##1 !DISCHARGE_GATE_OUT);
	key_use_c: cover property (key_ok && SLAVE_ADDRESS != `CPST_DEF_SLAVE_ADDR);
	irq_c: cover property (IRQ);
endmodule // cpst_top

// ===== verification/cpst_fet_model.sv
// behavioural model of the external high-side charge and discharge fets
`timescale 1ns/10ps
module cpst_fet_model (
	input wire logic chg_gate,
	input wire logic dis_gate,
	output logic chg_on,
	output logic dis_on
);
	// only a gate at pump level conducts; supply, ground or an unknown level leave the fet off
	assign chg_on = (chg_gate === 1'b1);
	assign dis_on = (dis_gate === 1'b1);
endmodule // cpst_fet_model

// ===== verification/cpst_top_test.sv
// self-checking bench for the protection status, gate control and trim block
`timescale 1ns/10ps
`include "cpst_params.svh"
module cpst_top_test;
	import cpst_pkg::*;
	localparam logic [7:0] FGT = 8'h5c;
	localparam logic [31:0] A_SSC = 32'h00000000;
	localparam logic [31:0] A_IST = 32'h00000004;
	localparam logic [31:0] A_IEN = 32'h00000008;
	localparam logic [31:0] A_ICL = 32'h0000000c;
	localparam logic [31:0] A_KEY = 32'h00000074;
	localparam logic [31:0] A_GAIN = 32'h00000078;
	localparam logic [31:0] A_VT = 32'h0000007c;
	localparam logic [31:0] A_ADC = 32'h00018028;
	logic clk, rst, hsel, hwrite, hreadyout, hresp, tchg, tdis, sleep, chg, dis, adc_en, irq, chg_on, dis_on;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] flt;
	cpst_word_t adc_cfg, vt;
	logic [6:0] sa;
	logic [7:0] gain, tco;
	int n_mismatch, num_checks;
	////////////////////////////////////////////////////////////////////////////
	cpst_top #(.FACTORY_GAIN_TRIM(FGT)) dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .CHARGE_OVERCURRENT_FAULT(flt[4]),
		.DISCHARGE_OVERCURRENT_FAULT(flt[3]), .SHORT_CIRCUIT_FAULT(flt[2]), .HIGH_CELL_VOLTAGE_FAULT(flt[1]),
		.LOW_CELL_VOLTAGE_FAULT(flt[0]), .CHARGE_TEMP_FAULT(tchg), .DISCHARGE_TEMP_FAULT(tdis),
		.SLEEP_ACTIVE(sleep), .CHARGE_GATE_OUT(chg), .DISCHARGE_GATE_OUT(dis), .ADC_ENABLE(adc_en),
		.ADC_CONFIG(adc_cfg), .VOLT_TEMP_TRIM(vt), .SLAVE_ADDRESS(sa), .CURRENT_GAIN_TRIM(gain),
		.SENSE_RESISTOR_TEMPCO(tco), .IRQ(irq));
	cpst_fet_model fets (.chg_gate(chg), .dis_gate(dis), .chg_on(chg_on), .dis_on(dis_on));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// hready is sampled at the rising edge; each phase is held until that edge sees it high
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		haddr <= a;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0, "response");
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		logic [31:0] x;
		bus(1'b1, a, {16'h0000, d}, x);
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [15:0] e, input string what);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, {16'h0000, e}, what);
	endtask
	task automatic gates(input int n, input logic [1:0] e, input string what);
		repeat (n) @(posedge clk);
		chk({30'h0, chg_on, dis_on}, {30'h0, e}, what);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd_chk(A_SSC, 16'h0000, "status after reset");
		chk({9'h0, sa, gain, tco}, {9'h0, `CPST_DEF_SLAVE_ADDR, FGT, 8'h00}, "trim defaults");
		chk({16'h0, vt}, {16'h0, `CPST_DEF_VT_WORD}, "volt temp default");
		gates(1, 2'b00, "fets off after reset");
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			wr(A_SSC, 16'h000c | 16'(m));
			gates(3, (m == 3) ? 2'b11 : 2'b00, "gates by mode");
			chk({31'h0, adc_en}, {31'h0, m != 0}, "adc enable");
			rd_chk(A_SSC, (m == 3) ? 16'h030f : (16'h000c | 16'(m)), "gate mirrors");
		end
		wr(A_SSC, 16'h0007);
		gates(3, 2'b01, "charge disabled");
		rd_chk(A_SSC, 16'h0107, "discharge mirror only");
		wr(A_SSC, 16'h000b);
		gates(3, 2'b10, "discharge disabled");
		rd_chk(A_SSC, 16'h020b, "charge mirror only");
	endtask
	task automatic t_faults;
		logic [4:0] f;
		logic [1:0] g;
		wr(A_SSC, 16'hf80f);
		rd_chk(A_SSC, 16'h030f, "ones to flags ignored");
		wr(A_IEN, 16'h001f);
		for (int i = 0; i < 5; i++) begin
			f = 5'h10 >> i;
			g = {!(f[4] | f[1] | f[0]), !(f[4] | f[3] | f[2] | f[0])};
			flt <= f;
			gates(5, g, "fault blocks gates");
			rd_chk(A_SSC, (16'h8000 >> i) | {6'h0, g, 8'h0f}, "fault flag set");
			chk({31'h0, irq}, 32'h1, "irq raised");
			wr(A_SSC, 16'h000f);
			gates(3, g, "enable cannot override");
			rd_chk(A_SSC, (16'h8000 >> i) | {6'h0, g, 8'h0f}, "clear refused while active");
			flt <= 5'h00;
			gates(5, 2'b11, "gates recover");
			rd_chk(A_SSC, (16'h8000 >> i) | 16'h030f, "flag sticky");
			wr(A_SSC, 16'h000f);
			rd_chk(A_SSC, 16'h030f, "flag cleared");
			rd_chk(A_IST, 16'h0010 >> i, "irq status");
			wr(A_ICL, 16'h001f);
			repeat (2) @(posedge clk);
			chk({31'h0, irq}, 32'h0, "irq cleared");
		end
		wr(A_IEN, 16'h0000);
		flt <= 5'h01;
		repeat (6) @(posedge clk);
		chk({31'h0, irq}, 32'h0, "irq masked");
		rd_chk(A_IST, 16'h0001, "masked status set");
		wr(A_IEN, 16'h0001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1, "irq unmasked");
		flt <= 5'h00;
		repeat (5) @(posedge clk);
		wr(A_SSC, 16'h000f);
		wr(A_ICL, 16'h0001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0, "irq cleared again");
	endtask
	task automatic t_trim;
		wr(A_GAIN, 16'ha41a);
		wr(A_VT, 16'h1780);
		wr(A_KEY, 16'h2a75);
		repeat (2) @(posedge clk);
		chk({9'h0, sa, gain, tco}, {9'h0, 7'h0b, FGT, 8'h00}, "bad key keeps defaults");
		chk({16'h0, vt}, {16'h0, `CPST_DEF_VT_WORD}, "bad key keeps vt");
		rd_chk(A_GAIN, 16'ha41a, "gain word readback");
		wr(A_KEY, 16'haa76);
		repeat (2) @(posedge clk);
		chk({9'h0, sa, gain, tco}, {9'h0, 7'h2a, 8'ha4, 8'h1a}, "user trim applied");
		chk({16'h0, vt}, 32'h00001780, "user vt applied");
		wr(A_SSC, 16'h000f);
		tchg <= 1'b1;
		gates(5, 2'b01, "charge temp fault");
		tchg <= 1'b0;
		tdis <= 1'b1;
		gates(5, 2'b10, "discharge temp fault");
		tdis <= 1'b0;
		sleep <= 1'b1;
		gates(5, 2'b00, "sleep blocks both");
		sleep <= 1'b0;
		gates(5, 2'b11, "awake again");
		wr(A_ADC, 16'h5a3c);
		repeat (2) @(posedge clk);
		chk({16'h0, adc_cfg}, 32'h00005a3c, "adc config out");
		rd_chk(A_ADC, 16'h5a3c, "adc config readback");
		wr(32'h00000040, 16'hffff);
		rd_chk(32'h00000040, 16'h0000, "unmapped reads zero");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		flt = 5'h00;
		tchg = 1'b0;
		tdis = 1'b0;
		sleep = 1'b0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_modes();
		t_faults();
		t_trim();
		conclude();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
endmodule // cpst_top_test
